// file: common/sadc_pkg.sv
// Package for the SAR converter sequencer: register layout and constants
`default_nettype none
package sadc_pkg;
    // ----------------------------------------------------------------
    // Register layout
    // ----------------------------------------------------------------
    localparam int unsigned SADC_DATA_BITS = 10;
    localparam int unsigned SADC_CH_BITS = 4;
    localparam logic [7:0] SADC_CSR_RESET = 8'h00;
    localparam logic [7:0] SADC_RES_RESET = 8'h00;
    localparam int unsigned SADC_CSR_DONE_BIT = 7;
    localparam int unsigned SADC_CSR_SPEED_BIT = 6;
    localparam int unsigned SADC_CSR_ON_BIT = 5;
    localparam logic [9:0] SADC_FULL_SCALE = 10'h3ff;
    localparam logic [9:0] SADC_ZERO_SCALE = 10'h000;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned SADC_DIV_SLOW = 4;
    localparam int unsigned SADC_DIV_FAST = 2;
    localparam int unsigned SADC_CONV_CYCLES = 12;
    localparam int unsigned SADC_SETTLE_NS = 1000;
    localparam int unsigned SADC_CLK_MHZ = 250;
    localparam int unsigned SADC_SETTLE_CYCLES =
        (SADC_SETTLE_NS * SADC_CLK_MHZ + 999) / 1000;

    // Software access strobes of one cycle
    typedef struct packed {
        logic csr_write;
        logic [7:0] csr_wdata;
        logic high_read;
        logic low_read;
    } sadc_access_type;

    // Analog core sample report
    typedef struct packed {
        logic [9:0] code;
        logic over_upper;
        logic under_lower;
    } sadc_sample_type;

    typedef enum logic [1:0] {
        SADC_OFF,
        SADC_SETTLE,
        SADC_CONVERT
    } sadc_state_type;
endpackage
`default_nettype wire

// file: logic/sadc_clock_divider.sv
// Converter tick generator: divide by 4 or by 2
`default_nettype none
module sadc_clock_divider
    import sadc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic run,
    input wire logic fast,
    // Tick out
    output logic tick
);
    logic [1:0] count;
    logic [1:0] next_count;
    logic [1:0] last;

    // Terminal count follows the speed selection
    always_comb begin
        last = fast ? 2'(SADC_DIV_FAST - 1) : 2'(SADC_DIV_SLOW - 1);
        if (!run || count >= last) begin
            next_count = 2'h0;
        end else begin
            next_count = count + 2'h1;
        end
        tick = run && (count >= last);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 2'h0;
        end else begin
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

// file: logic/sadc_sequencer.sv
// Control and result handling of the 10-bit SAR converter
`default_nettype none
module sadc_sequencer
    import sadc_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = SADC_CONV_CYCLES,
    parameter int unsigned SETTLE_CYCLES = SADC_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Software access
    input wire sadc_access_type access,
    output logic [7:0] converter_control_status_reg,
    output logic [7:0] result_high_reg,
    output logic [7:0] result_low_reg,
    // Power modes
    input wire logic cpu_wait,
    input wire logic cpu_halt,
    // Analog core
    input wire sadc_sample_type sample,
    output logic [15:0] mux_enable,
    output logic core_enable,
    output logic sample_strobe,
    output logic results_accurate
);
    // ----------------------------------------------------------------
    // Control register and flag
    // ----------------------------------------------------------------
    logic done;
    logic next_done;
    logic speed;
    logic next_speed;
    logic converter_on;
    logic next_converter_on;
    logic [3:0] channel_select;
    logic [3:0] next_channel_select;
    logic restart;
    logic finish;

    // A channel change counts only when the field really moves
    assign restart = access.csr_write &&
        access.csr_wdata[3:0] != channel_select;

    // Set wins over a clear in the same cycle so no result goes unseen
    always_comb begin
        next_speed = speed;
        next_converter_on = converter_on;
        next_channel_select = channel_select;
        next_done = done;
        if (access.csr_write) begin
            next_speed = access.csr_wdata[SADC_CSR_SPEED_BIT];
            next_converter_on = access.csr_wdata[SADC_CSR_ON_BIT];
            next_channel_select = access.csr_wdata[3:0];
            next_done = 1'b0;
        end
        if (access.high_read) begin
            next_done = 1'b0;
        end
        if (finish) begin
            next_done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= SADC_CSR_RESET[SADC_CSR_DONE_BIT];
            speed <= SADC_CSR_RESET[SADC_CSR_SPEED_BIT];
            converter_on <= SADC_CSR_RESET[SADC_CSR_ON_BIT];
            channel_select <= SADC_CSR_RESET[3:0];
        end else begin
            done <= next_done;
            speed <= next_speed;
            converter_on <= next_converter_on;
            channel_select <= next_channel_select;
        end
    end

    // Bit 4 reserved, reads zero; no interrupt output exists
    assign converter_control_status_reg =
        {done, speed, converter_on, 1'b0, channel_select};

    // ----------------------------------------------------------------
    // Converter sequencing
    // ----------------------------------------------------------------
    sadc_state_type state;
    sadc_state_type next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic tick;
    logic active;

    // Wait mode is deliberately not looked at here
    assign active = converter_on && !cpu_halt;

    sadc_clock_divider divider (
        .clk(clk),
        .reset_n(reset_n),
        .run(state == SADC_CONVERT && !restart),
        .fast(speed),
        .tick(tick)
    );

    // Gating on active stops a switch-off from landing one more result
    assign finish = state == SADC_CONVERT && active && tick && !restart &&
        count == 16'(CONV_CYCLES - 1);

    // Halt forces a settle period before results count as accurate
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            SADC_OFF: begin
                next_count = 16'h0;
                if (active) begin
                    next_state = SADC_CONVERT;
                end
            end
            SADC_SETTLE: begin
                if (cpu_halt) begin
                    next_state = SADC_OFF;
                    next_count = 16'h0;
                end else if (count == 16'(SETTLE_CYCLES - 1)) begin
                    next_state = active ? SADC_CONVERT : SADC_OFF;
                    next_count = 16'h0;
                end else begin
                    next_count = count + 16'h1;
                end
            end
            SADC_CONVERT: begin
                if (!active) begin
                    next_state = SADC_OFF;
                    next_count = 16'h0;
                end else if (restart) begin
                    next_count = 16'h0;
                end else if (finish) begin
                    next_count = 16'h0;
                end else if (tick) begin
                    next_count = count + 16'h1;
                end
            end
            default: begin
                next_state = SADC_OFF;
                next_count = 16'h0;
            end
        endcase
    end

    logic halted;
    logic next_halted;
    logic accurate;
    logic next_accurate;

    // Remember halt so the wake can route through the settle state
    always_comb begin
        next_halted = halted;
        next_accurate = accurate;
        if (cpu_halt) begin
            next_halted = 1'b1;
            next_accurate = 1'b0;
        end else if (state == SADC_SETTLE && next_state != SADC_SETTLE) begin
            next_accurate = 1'b1;
        end
        if (halted && !cpu_halt) begin
            next_halted = 1'b0;
        end
    end

    sadc_state_type next_state_final;
    logic [15:0] next_count_final;
    always_comb begin
        next_state_final = next_state;
        next_count_final = next_count;
        if (halted && !cpu_halt) begin
            next_state_final = SADC_SETTLE;
            next_count_final = 16'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SADC_OFF;
            count <= 16'h0;
            halted <= 1'b0;
            accurate <= 1'b1;
        end else begin
            state <= next_state_final;
            count <= next_count_final;
            halted <= next_halted;
            accurate <= next_accurate;
        end
    end

    assign core_enable = state == SADC_CONVERT;
    assign sample_strobe = finish;
    assign results_accurate = accurate;

    // One-hot mux select, channel n drives input n
    always_comb begin
        mux_enable = 16'h0;
        if (state == SADC_CONVERT) begin
            mux_enable[channel_select] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Result registers
    // ----------------------------------------------------------------
    logic [9:0] result;
    logic [9:0] next_result;
    logic [9:0] clipped;

    // Clip decisions override the core code
    always_comb begin
        if (sample.over_upper) begin
            clipped = SADC_FULL_SCALE;
        end else if (sample.under_lower) begin
            clipped = SADC_ZERO_SCALE;
        end else begin
            clipped = sample.code;
        end
        next_result = finish ? clipped : result;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= {SADC_RES_RESET, SADC_RES_RESET[1:0]};
        end else begin
            result <= next_result;
        end
    end

    // Not latched as a pair: a late reader may mix two conversions
    assign result_high_reg = result[9:2];
    assign result_low_reg = {6'h00, result[1:0]};

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_done_set: assert property (@(posedge clk) disable iff (!reset_n)
        finish |=> done)
        else $error("done not set after conversion");
    a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
        access.high_read && !finish |=> !done)
        else $error("high read did not clear done");
    a_write_clear: assert property (@(posedge clk) disable iff (!reset_n)
        access.csr_write && !finish |=> !done)
        else $error("csr write did not clear done");
    a_off_stops: assert property (@(posedge clk) disable iff (!reset_n)
        !converter_on |-> !finish ##1 !core_enable)
        else $error("result while converter off");
    a_sat_high: assert property (@(posedge clk) disable iff (!reset_n)
        finish && sample.over_upper |=>
        result_high_reg == 8'hff && result_low_reg == 8'h03)
        else $error("no saturation high");
    a_sat_low: assert property (@(posedge clk) disable iff (!reset_n)
        finish && !sample.over_upper && sample.under_lower |=>
        result_high_reg == 8'h00 && result_low_reg == 8'h00)
        else $error("no saturation low");
    a_chan_restart: assert property (@(posedge clk) disable iff (!reset_n)
        restart && state == SADC_CONVERT && active |=>
        count == 16'h0 && !done)
        else $error("channel change did not restart");
    a_halt_off: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_halt |=> !core_enable)
        else $error("converter ran in halt");
    a_wait_runs: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_wait && state == SADC_CONVERT && active |=> core_enable)
        else $error("wait mode stopped the converter");
    a_low_zero: assert property (@(posedge clk) disable iff (!reset_n)
        result_low_reg[7:2] == 6'h00)
        else $error("low register upper bits not zero");
    a_mux_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        core_enable |-> mux_enable == 16'h1 << channel_select)
        else $error("mux select wrong");
    c_finish: cover property (@(posedge clk) disable iff (!reset_n)
        finish);
    c_restart: cover property (@(posedge clk) disable iff (!reset_n)
        restart && state == SADC_CONVERT);
    c_wake: cover property (@(posedge clk) disable iff (!reset_n)
        state == SADC_SETTLE ##1 state == SADC_CONVERT);
endmodule
`default_nettype wire

// file: testbench/sadc_core_model.sv
// Behavioural model of the analog converter core and input multiplexer
`default_nettype none
module sadc_core_model
    import sadc_pkg::*;
(
    // Clock
    input wire logic clk,
    // From the sequencer
    input wire logic [15:0] mux_enable,
    input wire logic core_enable,
    // Bench control: 0 in range, 1 above, 2 below the references
    input wire logic [1:0] level_mode,
    // To the sequencer
    output sadc_sample_type sample
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Core outputs
    // ----------------------------------------------------------------
    logic [11:0] noise = 12'h000;
    logic [9:0] code;
    // Idle outputs change every cycle so a stale value never looks valid
    always_ff @(posedge clk) begin
        noise <= ~noise ^ 12'h5a3;
    end
    // Channel number on top, fixed fraction below, per selected input
    always_comb begin
        code = 10'h000;
        for (int i = 0; i < 16; i++) begin
            if (mux_enable[i]) begin
                code = {i[3:0], 6'h2a};
            end
        end
        if (!core_enable || $countones(mux_enable) != 1) begin
            sample = noise;
        end else if (level_mode == 2'h1) begin
            sample = {10'h155, 1'b1, 1'b0};
        end else if (level_mode == 2'h2) begin
            sample = {10'h0aa, 1'b0, 1'b1};
        end else begin
            sample = {code, 1'b0, 1'b0};
        end
    end
endmodule
`default_nettype wire

// file: testbench/sadc_sequencer_test.sv
// Self-checking bench for the SAR converter sequencer
`default_nettype none
module sadc_sequencer_test
    import sadc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run brief
    localparam int unsigned CONV = 3;
    localparam int unsigned SETTLE = 4;
    typedef struct {
        logic [3:0] ch;
        logic spd;
        logic [1:0] mode;
        logic [7:0] hi;
        logic [7:0] lo;
    } sadc_row_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cpu_wait = 1'b0;
    logic cpu_halt = 1'b0;
    logic [1:0] level_mode = 2'h0;
    sadc_access_type access = '0;
    sadc_sample_type sample;
    logic [7:0] csr;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [15:0] mux_enable;
    logic core_enable;
    logic sample_strobe;
    logic results_accurate;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    sadc_row_type rows [18];

    always #2 clk = ~clk;

    sadc_sequencer #(.CONV_CYCLES(CONV), .SETTLE_CYCLES(SETTLE)) uut (
        .clk(clk), .reset_n(reset_n), .access(access),
        .converter_control_status_reg(csr), .result_high_reg(res_hi),
        .result_low_reg(res_lo), .cpu_wait(cpu_wait),
        .cpu_halt(cpu_halt), .sample(sample), .mux_enable(mux_enable),
        .core_enable(core_enable), .sample_strobe(sample_strobe),
        .results_accurate(results_accurate));
    sadc_core_model core (.clk(clk), .mux_enable(mux_enable),
        .core_enable(core_enable), .level_mode(level_mode),
        .sample(sample));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Inputs move 1 ns after the edge, never on it
    task automatic cyc(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        access.csr_write = 1'b1;
        access.csr_wdata = d;
        cyc();
        access.csr_write = 1'b0;
    endtask
    task automatic rd(input logic hi_sel);
        access.high_read = hi_sel;
        access.low_read = !hi_sel;
        cyc();
        access.high_read = 1'b0;
        access.low_read = 1'b0;
    endtask
    // Bounded so a stuck flag cannot hang the run
    task automatic wait_done();
        n = 0;
        while (csr[7] !== 1'b1 && n < 200) begin
            cyc();
            n++;
        end
        chk("done wait", 16'h0, 16'(n >= 200));
    endtask
    task automatic wait_strobe(output int k);
        k = 0;
        do begin
            cyc();
            k++;
        end while (sample_strobe !== 1'b1 && k < 200);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the expected run of under a thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen hang");
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) begin
            rows[i] = '{i[3:0], i[0], 2'h0, {i[3:0], 4'ha}, 8'h02};
        end
        rows[16] = '{4'h7, 1'b1, 2'h1, 8'hff, 8'h03};
        rows[17] = '{4'h9, 1'b0, 2'h2, 8'h00, 8'h00};
        cyc(12);
        reset_n = 1'b1;
        chk("csr reset", 16'(SADC_CSR_RESET), 16'(csr));
        chk("high reset", 16'h0, 16'(res_hi));
        chk("low reset", 16'h0, 16'(res_lo));
        chk("core off", 16'h0, 16'(core_enable));
        chk("accurate", 16'h1, 16'(results_accurate));
        // Every channel, both speeds, both saturation cases
        foreach (rows[i]) begin
            level_mode = rows[i].mode;
            wr({1'b0, rows[i].spd, 1'b1, 1'b0, rows[i].ch});
            cyc();
            chk("mux", 16'h1 << rows[i].ch, mux_enable);
            chk("core on", 16'h1, 16'(core_enable));
            wait_done();
            rd(1'b0);
            cyc();
            chk("done after low", 16'h1, 16'(csr[7]));
            chk("low", 16'(rows[i].lo), 16'(res_lo));
            chk("high", 16'(rows[i].hi), 16'(res_hi));
            rd(1'b1);
            cyc();
            chk("done after high", 16'h0, 16'(csr[7]));
            wait_done();
        end
        // Conversion length in CPU cycles follows the speed bit
        level_mode = 2'h0;
        wr(8'h23);
        wait_strobe(n);
        wait_strobe(n);
        chk("slow period", 16'(CONV * SADC_DIV_SLOW), 16'(n));
        wr(8'h63);
        wait_strobe(n);
        wait_strobe(n);
        chk("fast period", 16'(CONV * SADC_DIV_FAST), 16'(n));
        // Channel change in mid-conversion with a result pending
        wait_done();
        cyc(2);
        wr(8'h65);
        cyc();
        chk("done on change", 16'h0, 16'(csr[7]));
        chk("new mux", 16'h0020, mux_enable);
        wait_done();
        chk("new channel", 16'h005a, 16'(res_hi));
        // Rewriting the same value still clears done
        wr(8'h65);
        cyc();
        chk("done on write", 16'h0, 16'(csr[7]));
        // Unread result is overwritten by the next conversion
        wait_done();
        level_mode = 2'h1;
        wait_strobe(n);
        cyc();
        chk("overwrite high", 16'h00ff, 16'(res_hi));
        chk("overwrite low", 16'h0003, 16'(res_lo));
        // Wait mode keeps conversions going
        cpu_wait = 1'b1;
        level_mode = 2'h0;
        wr(8'h65);
        wait_done();
        chk("wait result", 16'h005a, 16'(res_hi));
        cpu_wait = 1'b0;
        // Switching off stops everything and produces nothing
        wr(8'h45);
        cyc();
        chk("off core", 16'h0, 16'(core_enable));
        chk("off mux", 16'h0, mux_enable);
        wait_strobe(n);
        chk("no strobe off", 16'd200, 16'(n));
        chk("no done off", 16'h0, 16'(csr[7]));
        // Halt stops the core; wake goes through settling
        wr(8'h65);
        cyc(2);
        cpu_halt = 1'b1;
        cyc(2);
        chk("halt core", 16'h0, 16'(core_enable));
        cpu_halt = 1'b0;
        cyc();
        chk("not settled", 16'h0, 16'(results_accurate));
        n = 0;
        while (results_accurate !== 1'b1 && n < 50) begin
            cyc();
            n++;
        end
        chk("settle", 16'(SETTLE), 16'(n));
        wait_done();
        chk("after wake", 16'h005a, 16'(res_hi));
        // Reset in mid-run clears all registers
        cyc(3);
        reset_n = 1'b0;
        cyc(2);
        chk("csr rerun", 16'h0, 16'(csr));
        chk("high rerun", 16'h0, 16'(res_hi));
        reset_n = 1'b1;
        cyc();
        chk("core rerun", 16'h0, 16'(core_enable));
        give_verdict();
    end
endmodule
`default_nettype wire
